// *** afc_pkg.sv ***
`default_nettype none
// ============================================================
// timing and command constants for the flash bus host
package afc_pkg;
    // clock
    localparam int CLK_NS = 8;
    localparam int SYNC_CYC = 2;
    // minimum bus times in ns
    localparam int T_RC_NS = 70;
    localparam int T_WC_NS = 70;
    localparam int T_WP_NS = 30;
    localparam int T_WPH_NS = 30;
    localparam int T_DS_NS = 40;
    localparam int T_OEH_NS = 10;
    localparam int T_BUSY_NS = 90;
    localparam int T_RH_NS = 50;
    localparam int T_RP_NS = 500;
    localparam int T_HQV_NS = 70;
    localparam int T_LQZ_NS = 25;
    // reset and unprotect times in us, erase time in s
    localparam int T_READY_US = 20;
    localparam int T_RSP_US = 4;
    localparam int T_RRB_US = 4;
    localparam int T_SE_S = 1;
    // cycle counts, minimums rounded up
    localparam int C_RC = (T_RC_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_WC = (T_WC_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_WP = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_WPH = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_DS = (T_DS_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_OEH = (T_OEH_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_BUSY = (T_BUSY_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_RH = (T_RH_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_RP = (T_RP_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_HQV = (T_HQV_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_LQZ = (T_LQZ_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_READY = (T_READY_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int C_RSP = (T_RSP_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int C_RRB = (T_RRB_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int C_SE = T_SE_S * 1000000000 / CLK_NS;
    // derived phase lengths
    localparam int C_RD = C_RC + SYNC_CYC;
    localparam int C_WL = (C_WP > C_DS) ? C_WP : C_DS;
    localparam int C_WH = (C_WPH > C_WC - C_WL) ? C_WPH : C_WC - C_WL;
    localparam int C_BW = C_BUSY + SYNC_CYC;
    localparam int C_RLO = (C_READY > C_RP) ? C_READY : C_RP;
    localparam int ERASE_MARGIN = 4;
    localparam int PROG_STEPS = 4;
    // user commands
    typedef enum logic [2:0] {
        AFC_READ = 3'h0,
        AFC_WRITE = 3'h1,
        AFC_PROG = 3'h2,
        AFC_POLL = 3'h3,
        AFC_WAITR = 3'h4,
        AFC_RESET = 3'h5,
        AFC_WIDTH = 3'h6,
        AFC_UNPROT = 3'h7
    } afc_cmd_e;
    // controller states, gray along the usual path
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_RD = 4'h1,
        ST_OEH = 4'h3,
        ST_WRLO = 4'h2,
        ST_WRHI = 4'h6,
        ST_BUSYW = 4'h7,
        ST_SETTLE = 4'h5,
        ST_RSTLO = 4'h4,
        ST_RSTHI = 4'hC
    } afc_state_e;
endpackage
`default_nettype wire

// *** afc_sync.sv ***
`default_nettype none
// ============================================================
// two flop synchroniser for pin inputs
module afc_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } afc_sync_s;
    afc_sync_s r_r;
    afc_sync_s r_nxt;
    // first stage feeds only the second
    always_comb begin
        r_nxt.s1 = d;
        r_nxt.s2 = r_r.s1;
    end
    // registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end
    assign q = r_r.s2;
endmodule
`default_nettype wire

// *** afc_host.sv ***
`default_nettype none
module afc_host import afc_pkg::*; #(
    parameter int AW = 21,
    parameter int DW = 16,
    parameter logic [31:0] TIMEOUT_CYC = 32'(C_SE * ERASE_MARGIN),
    parameter logic [AW-1:0] UNLK_ADDR1 = AW'(16'h0555),
    parameter logic [AW-1:0] UNLK_ADDR2 = AW'(16'h02AA),
    parameter logic [DW-1:0] UNLK_DATA1 = DW'(8'hAA),
    parameter logic [DW-1:0] UNLK_DATA2 = DW'(8'h55),
    parameter logic [DW-1:0] PROG_CODE = DW'(8'hA0)
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // user request
    input wire logic req,
    input wire logic [2:0] cmd,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    // user answer
    output logic [DW-1:0] rdata,
    output logic done,
    output logic err,
    output logic busy,
    // flash control pins
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic flash_rst_n,
    output logic flash_byte_n,
    output logic flash_vid_en,
    // flash address and data pins
    output logic [AW-1:0] flash_addr,
    output logic [DW-1:0] flash_dq_o,
    output logic flash_dq_oe,
    input wire logic [DW-1:0] flash_dq_i,
    input wire logic ready_busy_flag
);
    typedef struct packed {
        afc_state_e st;
        afc_cmd_e cmd;
        logic [31:0] cnt;
        logic [1:0] step;
        logic arg;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic rst_n;
        logic byte_n;
        logic vid_en;
        logic dq_oe;
        logic [AW-1:0] addr;
        logic [DW-1:0] dq_o;
        logic [AW-1:0] uaddr;
        logic [DW-1:0] udata;
        logic [DW-1:0] rdata;
        logic done;
        logic err;
        logic busy;
    } afc_host_s;

    afc_host_s r_r;
    afc_host_s r_nxt;
    logic [DW:0] pin_s;
    logic rdy_s;
    logic [DW-1:0] dq_s;

    // ============================================================
    // pin input synchronisers
    afc_sync #(.W(DW + 1)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .d({ready_busy_flag, flash_dq_i}),
        .q(pin_s)
    );
    assign rdy_s = pin_s[DW];
    assign dq_s = pin_s[DW-1:0];

    // address and data of one step of the program sequence
    function automatic logic [AW+DW-1:0] prog_word(input logic [1:0] s,
            input logic [AW-1:0] a, input logic [DW-1:0] d);
        logic [AW+DW-1:0] w;
        w = {a, d};
        unique case (s)
            2'h0: w = {UNLK_ADDR1, UNLK_DATA1};
            2'h1: w = {UNLK_ADDR2, UNLK_DATA2};
            2'h2: w = {UNLK_ADDR1, PROG_CODE};
            2'h3: w = {a, d};
        endcase
        return w;
    endfunction

    // ============================================================
    // bus sequencer
    always_comb begin
        r_nxt = r_r;
        r_nxt.done = 1'b0;
        r_nxt.err = 1'b0;
        if (r_r.cnt != 32'h0) begin
            r_nxt.cnt = r_r.cnt - 32'h1;
        end
        unique case (r_r.st)
            ST_IDLE: begin
                if (req) begin
                    r_nxt.cmd = afc_cmd_e'(cmd);
                    r_nxt.uaddr = addr;
                    r_nxt.udata = wdata;
                    r_nxt.arg = wdata[0];
                    r_nxt.step = 2'h0;
                    unique case (afc_cmd_e'(cmd))
                        AFC_READ, AFC_POLL: begin
                            if (cmd == AFC_READ && !rdy_s) begin
                                r_nxt.done = 1'b1;
                                r_nxt.err = 1'b1;
                            end else begin
                                r_nxt.st = ST_RD;
                                r_nxt.ce_n = 1'b0;
                                r_nxt.oe_n = 1'b0;
                                r_nxt.addr = addr;
                                r_nxt.cnt = 32'(C_RD - 1);
                            end
                        end
                        AFC_WRITE, AFC_PROG: begin
                            if (cmd == AFC_PROG && !rdy_s) begin
                                r_nxt.done = 1'b1;
                                r_nxt.err = 1'b1;
                            end else begin
                                r_nxt.st = ST_WRLO;
                                r_nxt.ce_n = 1'b0;
                                r_nxt.we_n = 1'b0;
                                r_nxt.dq_oe = 1'b1;
                                {r_nxt.addr, r_nxt.dq_o} =
                                    (cmd == AFC_PROG) ?
                                    prog_word(2'h0, addr, wdata) :
                                    {addr, wdata};
                                r_nxt.cnt = 32'(C_WL - 1);
                            end
                        end
                        AFC_WAITR: begin
                            r_nxt.st = ST_BUSYW;
                            r_nxt.cnt = 32'(C_BW - 1);
                        end
                        AFC_RESET: begin
                            r_nxt.st = ST_RSTLO;
                            r_nxt.rst_n = 1'b0;
                            r_nxt.cnt = 32'(C_RLO - 1);
                        end
                        AFC_WIDTH: begin
                            r_nxt.st = ST_SETTLE;
                            r_nxt.byte_n = wdata[0];
                            r_nxt.cnt = wdata[0] ? 32'(C_HQV - 1)
                                                 : 32'(C_LQZ - 1);
                        end
                        AFC_UNPROT: begin
                            if (wdata[0]) begin
                                r_nxt.st = ST_SETTLE;
                                r_nxt.vid_en = 1'b1;
                                r_nxt.cnt = 32'(C_RSP - 1);
                            end else begin
                                r_nxt.st = ST_BUSYW;
                                r_nxt.step = 2'h1;
                                r_nxt.cnt = TIMEOUT_CYC - 32'h1;
                            end
                        end
                    endcase
                end
            end
            ST_RD: begin
                if (r_r.cnt == 32'h0) begin
                    r_nxt.rdata = dq_s;
                    r_nxt.ce_n = 1'b1;
                    r_nxt.oe_n = 1'b1;
                    if (r_r.cmd == AFC_POLL) begin
                        r_nxt.st = ST_OEH;
                        r_nxt.cnt = 32'(C_OEH - 1);
                    end else begin
                        r_nxt.st = ST_IDLE;
                        r_nxt.done = 1'b1;
                    end
                end
            end
            ST_OEH: begin
                if (r_r.cnt == 32'h0) begin
                    r_nxt.st = ST_IDLE;
                    r_nxt.done = 1'b1;
                end
            end
            ST_WRLO: begin
                if (r_r.cnt == 32'h0) begin
                    r_nxt.st = ST_WRHI;
                    r_nxt.we_n = 1'b1;
                    r_nxt.cnt = 32'(C_WH - 1);
                end
            end
            ST_WRHI: begin
                if (r_r.cnt == 32'h0) begin
                    if (r_r.cmd == AFC_PROG && r_r.step != 2'h3) begin
                        r_nxt.st = ST_WRLO;
                        r_nxt.step = r_r.step + 2'h1;
                        r_nxt.we_n = 1'b0;
                        {r_nxt.addr, r_nxt.dq_o} = prog_word(
                            r_r.step + 2'h1, r_r.uaddr, r_r.udata);
                        r_nxt.cnt = 32'(C_WL - 1);
                    end else begin
                        r_nxt.ce_n = 1'b1;
                        r_nxt.dq_oe = 1'b0;
                        if (r_r.cmd == AFC_PROG) begin
                            r_nxt.st = ST_BUSYW;
                            r_nxt.step = 2'h0;
                            r_nxt.cnt = 32'(C_BW - 1);
                        end else begin
                            r_nxt.st = ST_IDLE;
                            r_nxt.done = 1'b1;
                        end
                    end
                end
            end
            ST_BUSYW: begin
                if (r_r.step == 2'h0) begin
                    if (r_r.cnt == 32'h0) begin
                        r_nxt.step = 2'h1;
                        r_nxt.cnt = TIMEOUT_CYC - 32'h1;
                    end
                end else if (rdy_s) begin
                    if (r_r.cmd == AFC_UNPROT) begin
                        r_nxt.st = ST_SETTLE;
                        r_nxt.cnt = 32'(C_RRB - 1);
                    end else begin
                        r_nxt.st = ST_IDLE;
                        r_nxt.done = 1'b1;
                    end
                end else if (r_r.cnt == 32'h0) begin
                    r_nxt.st = ST_IDLE;
                    r_nxt.done = 1'b1;
                    r_nxt.err = 1'b1;
                end
            end
            ST_SETTLE: begin
                if (r_r.cnt == 32'h0) begin
                    if (r_r.cmd == AFC_UNPROT && !r_r.arg) begin
                        r_nxt.vid_en = 1'b0;
                    end
                    r_nxt.st = ST_IDLE;
                    r_nxt.done = 1'b1;
                end
            end
            ST_RSTLO: begin
                if (r_r.cnt == 32'h0) begin
                    r_nxt.st = ST_RSTHI;
                    r_nxt.rst_n = 1'b1;
                    r_nxt.cnt = 32'(C_RH - 1);
                end
            end
            ST_RSTHI: begin
                if (r_r.cnt == 32'h0) begin
                    r_nxt.st = ST_IDLE;
                    r_nxt.done = 1'b1;
                end
            end
            default: begin
                r_nxt.st = ST_IDLE;
            end
        endcase
        // busy registered with the state it follows
        r_nxt.busy = (r_nxt.st != ST_IDLE);
    end

    // state register, ce_n oe_n we_n rst_n byte_n idle high after reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r_r <= '0;
            r_r.st <= ST_IDLE;
            r_r.ce_n <= 1'b1;
            r_r.oe_n <= 1'b1;
            r_r.we_n <= 1'b1;
            r_r.rst_n <= 1'b1;
            r_r.byte_n <= 1'b1;
        end else begin
            r_r <= r_nxt;
        end
    end

    // outputs straight from the state register
    assign rdata = r_r.rdata;
    assign done = r_r.done;
    assign err = r_r.err;
    assign busy = r_r.busy;
    assign flash_ce_n = r_r.ce_n;
    assign flash_oe_n = r_r.oe_n;
    assign flash_we_n = r_r.we_n;
    assign flash_rst_n = r_r.rst_n;
    assign flash_byte_n = r_r.byte_n;
    assign flash_vid_en = r_r.vid_en;
    assign flash_addr = r_r.addr;
    assign flash_dq_o = r_r.dq_o;
    assign flash_dq_oe = r_r.dq_oe;

    // ============================================================
    // checks
    logic [15:0] rlo_cnt;
    logic [15:0] vid_cnt;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rlo_cnt <= 16'h0;
            vid_cnt <= 16'h0;
        end else begin
            rlo_cnt <= r_r.rst_n ? 16'h0 : rlo_cnt + 16'h1;
            vid_cnt <= !r_r.vid_en ? 16'h0 :
                       (vid_cnt == 16'hFFFF) ? vid_cnt : vid_cnt + 16'h1;
        end
    end
    sequence s_oe_held;
        !flash_oe_n [*8] ##1 !flash_oe_n;
    endsequence
    sequence s_we_low;
        !flash_we_n [*5];
    endsequence
    property p_read_len;
        @(posedge clk) disable iff (sys_rst) $fell(flash_oe_n) |-> s_oe_held;
    endproperty
    a_read_len: assert property (p_read_len) else $error("short read");
    property p_wr_cycle;
        @(posedge clk) disable iff (sys_rst)
            $fell(flash_we_n) |-> s_we_low ##1 flash_we_n [*4];
    endproperty
    a_wr_cycle: assert property (p_wr_cycle) else $error("short wr");
    property p_we_high;
        @(posedge clk) disable iff (sys_rst)
            $rose(flash_we_n) |-> flash_we_n [*4];
    endproperty
    a_we_high: assert property (p_we_high) else $error("we high");
    property p_poll_gap;
        @(posedge clk) disable iff (sys_rst)
            $rose(flash_oe_n) && r_r.cmd == AFC_POLL |-> !done ##1 !done
            ##1 done;
    endproperty
    a_poll_gap: assert property (p_poll_gap) else $error("oe gap");
    property p_rst_len;
        @(posedge clk) disable iff (sys_rst)
            $rose(flash_rst_n) |-> rlo_cnt >= 16'(C_READY);
    endproperty
    a_rst_len: assert property (p_rst_len) else $error("reset short");
    property p_rst_rec;
        @(posedge clk) disable iff (sys_rst)
            $rose(flash_rst_n) |-> (flash_oe_n && flash_we_n) [*8] ##0 done;
    endproperty
    a_rst_rec: assert property (p_rst_rec) else $error("reset rec");
    property p_vid_setup;
        @(posedge clk) disable iff (sys_rst)
            $fell(flash_we_n) && flash_vid_en |-> vid_cnt >= 16'(C_RSP);
    endproperty
    a_vid_setup: assert property (p_vid_setup) else $error("vid");
    property p_busy_read;
        @(posedge clk) disable iff (sys_rst)
            r_r.st == ST_IDLE && req && cmd == AFC_READ && !rdy_s
            |=> done && err && flash_oe_n;
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("busy rd");
    property p_word_wait;
        @(posedge clk) disable iff (sys_rst)
            $rose(flash_byte_n) |-> !done [*8] ##1 !done ##1 done;
    endproperty
    a_word_wait: assert property (p_word_wait) else $error("word");
endmodule
`default_nettype wire

// *** afc_fm.sv ***
`default_nettype none
// ============================================================
// flash device model seen from the host pins
module afc_fm import afc_pkg::*; #(
    parameter int BUSY_CYC = 60
) (
    // clock and test control
    input wire logic clk,
    input wire logic stall,
    // control pins
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic rst_n,
    input wire logic byte_n,
    // address and data
    input wire logic [20:0] addr,
    input wire logic [15:0] dq_o,
    input wire logic dq_oe,
    output logic [15:0] dq_i,
    output logic ready_busy_flag
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [16];
    logic [15:0] last = '0;
    logic [15:0] pd;
    logic [15:0] drv;
    logic [3:0] pa;
    logic [1:0] step = '0;
    logic we_q = 1'b1;
    logic standby = 1'b0;
    logic hit;
    int busy_cnt = 0;
    int rst_cnt = 0;
    // array contents that the bench predicts
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = 16'(16'h1357 * (i + 1));
        end
    end
    // unlock cycle match for the current step
    always_comb begin
        case (step)
            2'h0: hit = addr[11:0] == 12'h555 && dq_o[7:0] == 8'hAA;
            2'h1: hit = addr[11:0] == 12'h2AA && dq_o[7:0] == 8'h55;
            2'h2: hit = addr[11:0] == 12'h555 && dq_o[7:0] == 8'hA0;
            default: hit = 1'b1;
        endcase
    end
    // command decode, embedded program and reset abort
    always @(posedge clk) begin
        we_q <= we_n;
        last <= dq_i;
        if (!rst_n) begin
            busy_cnt <= 0;
            step <= 2'h0;
            rst_cnt <= rst_cnt + 1;
            standby <= rst_cnt >= C_READY;
        end else begin
            rst_cnt <= 0;
            standby <= 1'b0;
            if (busy_cnt > 0 && !stall) begin
                busy_cnt <= busy_cnt - 1;
            end
            if (busy_cnt == 1 && !stall) begin
                mem[pa] <= pd;
            end
            if (we_n && !we_q && !ce_n && busy_cnt == 0) begin
                step <= hit ? step + 2'h1 : 2'h0;
                if (step == 2'h3) begin
                    pa <= addr[3:0];
                    pd <= dq_o;
                    busy_cnt <= BUSY_CYC;
                end
            end
        end
    end
    // ready flag low for the whole embedded operation
    assign ready_busy_flag = busy_cnt == 0;
    // status while busy, upper lines floating in byte mode
    always_comb begin
        drv = busy_cnt != 0 ? ~pd : mem[addr[3:0]];
        if (!byte_n) begin
            drv[15:8] = ~last[15:8];
        end
    end
    // a released bus never shows its stale value
    assign dq_i = dq_oe ? dq_o
        : (!ce_n && !oe_n && rst_n && !standby) ? drv : ~last;
endmodule
`default_nettype wire

// *** tb.sv ***
`default_nettype none
// ============================================================
// self-checking bench for the flash bus host
module tb import afc_pkg::*; ();
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TO_CYC = 2000;
    localparam int BUSY_CYC = 60;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic req = 1'b0;
    logic stall = 1'b0;
    logic [2:0] cmd = 3'h0;
    logic [20:0] addr = '0;
    logic [15:0] wdata = '0;
    logic [15:0] rdata, dq_o, dq_i;
    logic [20:0] f_addr;
    logic done, err, busy, ce_n, oe_n, we_n, rst_n;
    logic byte_n, vid_en, dq_oe, rbf;
    int n_errors = 0;
    int comparisons = 0;
    int n_oe, n_we, n_rst, vid_run, rdy_run;
    int hi_run = 999, fall_run = 999, oeh_run = 999, rh_run = 999;
    logic we_q = 1'b1, oe_q = 1'b1, vid_q = 1'b0;
    logic [36:0] wq [$];
    integer seed = 32'h5866C38F;

    afc_host #(.TIMEOUT_CYC(32'(TO_CYC))) dut (
        .clk(clk), .sys_rst(sys_rst), .req(req), .cmd(cmd),
        .addr(addr), .wdata(wdata), .rdata(rdata), .done(done),
        .err(err), .busy(busy), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
        .flash_we_n(we_n), .flash_rst_n(rst_n), .flash_byte_n(byte_n),
        .flash_vid_en(vid_en), .flash_addr(f_addr), .flash_dq_o(dq_o),
        .flash_dq_oe(dq_oe), .flash_dq_i(dq_i), .ready_busy_flag(rbf));
    afc_fm #(.BUSY_CYC(BUSY_CYC)) fm (
        .clk(clk), .stall(stall), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .rst_n(rst_n), .byte_n(byte_n), .addr(f_addr), .dq_o(dq_o),
        .dq_oe(dq_oe), .dq_i(dq_i), .ready_busy_flag(rbf));

    // 125 MHz clock
    initial begin
        forever #4 clk = ~clk;
    end

    // value compare and minimum compare
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask
    task automatic chk_ge(input int got, input int lo);
        comparisons++;
        if (got < lo) begin
            n_errors++;
            $display("unexpected at %0t: got %0h min %0h", $time, got, lo);
        end
    endtask
    task automatic give_verdict();
        if (n_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    function automatic logic [15:0] init_word(input logic [3:0] a);
        return 16'(32'h1357 * (32'(a) + 1));
    endfunction

    // one user command, returns cycles from take edge to done
    task automatic run(input logic [2:0] c, input logic [20:0] a,
                       input logic [15:0] d, output int cyc);
        n_oe = 0;
        n_we = 0;
        n_rst = 0;
        cmd = c;
        addr = a;
        wdata = d;
        req = 1'b1;
        @(posedge clk);
        #1 req = 1'b0;
        cyc = 1;
        while (done !== 1'b1) begin
            @(posedge clk);
            #1 cyc++;
            if (cyc > 6000) begin
                n_errors++;
                give_verdict();
            end
        end
    endtask

    // pin spacing monitor
    always @(posedge clk) begin
        if (!oe_n && oe_q) begin
            if (cmd == AFC_POLL) chk_ge(oeh_run, C_OEH);
            chk_ge(rh_run, C_RH);
        end
        if (!we_n && we_q) begin
            chk_ge(hi_run, C_WPH);
            chk_ge(fall_run, C_WC);
            if (vid_en) chk_ge(vid_run, C_RSP);
            fall_run = 0;
        end
        if (!vid_en && vid_q) chk_ge(rdy_run, C_RRB);
        if (we_n && !we_q && !ce_n) wq.push_back({f_addr, dq_o});
        n_oe = n_oe + (oe_n ? 0 : 1);
        n_we = n_we + (we_n ? 0 : 1);
        n_rst = n_rst + (rst_n ? 0 : 1);
        oeh_run = oe_n ? oeh_run + 1 : 0;
        hi_run = we_n ? hi_run + 1 : 0;
        rh_run = rst_n ? rh_run + 1 : 0;
        vid_run = vid_en ? vid_run + 1 : 0;
        rdy_run = rbf ? rdy_run + 1 : 0;
        fall_run++;
        we_q = we_n;
        oe_q = oe_n;
        vid_q = vid_en;
    end

    // main sequence
    initial begin
        int c;
        logic [20:0] a;
        logic [15:0] d;
        logic [36:0] e;
        logic [20:0] ea [4];
        logic [15:0] ed [4];
        repeat (5) @(posedge clk);
        #1;
        chk({ce_n, oe_n, we_n, rst_n, byte_n, vid_en, dq_oe, busy, done},
            9'h1F0);
        sys_rst = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        // random reads
        for (int i = 0; i < 4; i++) begin
            a = 21'($random(seed));
            run(AFC_READ, a, 16'h0000, c);
            chk(c, 12);
            chk(n_oe, C_RD);
            chk(rdata, init_word(a[3:0]));
            chk({err, busy}, 2'h0);
        end
        // single write away from unlock addresses
        a = 21'($random(seed)) & ~21'hFFF;
        run(AFC_WRITE, a, 16'($random(seed)), c);
        chk(c, 10);
        chk(n_we, C_WL);
        // program and read back
        wq.delete();
        a = 21'($random(seed)) & ~21'h8;
        d = 16'($random(seed));
        ea = '{21'h555, 21'h2AA, 21'h555, a};
        ed = '{16'h00AA, 16'h0055, 16'h00A0, d};
        run(AFC_PROG, a, d, c);
        chk(err, 1'b0);
        chk_ge(c, BUSY_CYC);
        chk(wq.size(), 4);
        for (int i = 0; i < 4 && wq.size() > 0; i++) begin
            e = wq.pop_front();
            chk({e[36:16], e[15:0]}, {ea[i], ed[i]});
        end
        run(AFC_READ, a, 16'h0000, c);
        chk(rdata, d);
        // stalled program: timeout, refusal, polls, reset abort
        stall = 1'b1;
        a = 21'($random(seed)) | 21'h8;
        d = 16'($random(seed));
        run(AFC_PROG, a, d, c);
        chk(err, 1'b1);
        chk_ge(c, TO_CYC);
        run(AFC_READ, a, 16'h0000, c);
        chk({c[7:0], err}, 9'h003);
        for (int i = 0; i < 2; i++) begin
            run(AFC_POLL, a, 16'h0000, c);
            chk(c, 14);
            chk(rdata, 16'(~d));
        end
        run(AFC_RESET, 21'h0, 16'h0000, c);
        stall = 1'b0;
        chk(c, 2508);
        chk(n_rst, C_RLO);
        run(AFC_WAITR, 21'h0, 16'h0000, c);
        chk(err, 1'b0);
        run(AFC_READ, a, 16'h0000, c);
        chk(rdata, init_word(a[3:0]));
        // width switching
        run(AFC_WIDTH, 21'h0, 16'h0000, c);
        chk({c[7:0], byte_n}, 9'h00A);
        run(AFC_READ, a, 16'h0000, c);
        chk(rdata[7:0], init_word(a[3:0]) & 16'h00FF);
        run(AFC_WIDTH, 21'h0, 16'h0001, c);
        chk({c[7:0], byte_n}, 9'h015);
        run(AFC_READ, a, 16'h0000, c);
        chk(rdata, init_word(a[3:0]));
        // temporary unprotect enter, write, exit
        run(AFC_UNPROT, 21'h0, 16'h0001, c);
        chk({c[15:0], vid_en}, 17'h003EB);
        run(AFC_WRITE, 21'h0, 16'h0060, c);
        run(AFC_UNPROT, 21'h0, 16'h0000, c);
        chk_ge(c, C_RRB);
        chk(vid_en, 1'b0);
        give_verdict();
    end
endmodule
`default_nettype wire
